// ===== core/isgp_map.svh
// Register map, field positions, reset values and timing counts of the serial GPIO port.
// Assumes a 100 MHz system clock; included by every file that needs a figure.
`ifndef ISGP_MAP_SVH
`define ISGP_MAP_SVH

`define ISGP_SLAVE_ADDR     7'h59
`define ISGP_REG_CTRL       8'h06
`define ISGP_REG_DATA       8'h07
`define ISGP_CTRL_PWM_BIT   4
`define ISGP_DIR_RESET      3'h0
`define ISGP_PWM_RESET      1'b0
`define ISGP_DATA_RESET     3'h0
`define ISGP_CLK_PERIOD_NS  10
`define ISGP_HOLD_NS        300
`define ISGP_HOLD_CYC       ((`ISGP_HOLD_NS + `ISGP_CLK_PERIOD_NS - 1) / `ISGP_CLK_PERIOD_NS)

`endif

// ===== core/isgp_pkg.sv
// Types shared by the serial GPIO port.
// Assumes nothing of its surroundings.
package isgp_pkg;

	typedef enum logic [9:0] {
		ST_IDLE      = 10'h001,
		ST_ADDR      = 10'h002,
		ST_ACK_ADDR  = 10'h004,
		ST_PTR       = 10'h008,
		ST_ACK_PTR   = 10'h010,
		ST_WDATA     = 10'h020,
		ST_ACK_WDATA = 10'h040,
		ST_RDATA     = 10'h080,
		ST_RACK      = 10'h100,
		ST_IGNORE    = 10'h200
	} isgp_state_t;

endpackage : isgp_pkg

// ===== core/isgp_sync.sv
// Two-flop synchroniser, one chain per bit.
// Assumes inputs are asynchronous to i_clk and read only after the second flop.
`timescale 1ns/1ns
`default_nettype none

module isgp_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic [WIDTH-1:0] i_async,
	output var  logic [WIDTH-1:0] o_sync
);

	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++)
		begin : g_chain
			logic meta;
			always_ff @(posedge i_clk)
			begin
				meta        <= i_async[gi];
				o_sync[gi]  <= meta;
			end
		end
	endgenerate

endmodule : isgp_sync

`default_nettype wire

// ===== core/isgp_link.sv
// Link-side bit sampler, clocked by the bus clock itself.
// Assumes the bus clock stands still between frames; each rising edge hands one bit over.
`timescale 1ns/1ns
`default_nettype none

module isgp_link (
	input  wire logic i_scl,
	input  wire logic i_link_rst,
	input  wire logic i_sda,
	output var  logic o_bit,
	output var  logic o_toggle
);

	// Bit is held until the next edge, so the toggle alone marks it new
	always_ff @(posedge i_scl or posedge i_link_rst)
	begin
		if (i_link_rst)
		begin
			o_bit    <= 1'b1;
			o_toggle <= 1'b0;
		end
		else
		begin
			o_bit    <= i_sda;
			o_toggle <= ~o_toggle;
		end
	end

endmodule : isgp_link

`default_nettype wire

// ===== core/isgp_top.sv
// Serial register-access slave with three general purpose pins.
// Assumes a bus master that makes the bus clock, open-drain SDA resolved outside,
// and pins resolved from o_gpio_out and o_gpio_oe outside.
`timescale 1ns/1ns
`default_nettype none
`include "isgp_map.svh"

module isgp_top
	import isgp_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_srst,
	input  wire logic       i_external_reset_n,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda_out,
	output logic            o_sda_oe,
	input  wire logic [2:0] i_gpio_in,
	output logic      [2:0] o_gpio_out,
	output logic      [2:0] o_gpio_oe,
	output logic            o_pwm_input,
	output logic            o_bus_busy
);

	////////////////////////////////////////////////////////////////////////////////
	// Crossings

	logic [6:0]  sync_out;
	logic        scl_s;
	logic        sda_s;
	logic [2:0]  gpio_s;
	logic        ext_n_s;
	logic        tog_s;
	logic        link_bit;
	logic        link_tog;
	logic        link_rst;

	isgp_sync #(
		.WIDTH (7)
	) u_sync (
		.i_clk   (i_clk),
		.i_async ({link_tog, i_external_reset_n, i_gpio_in, i_sda, i_scl}),
		.o_sync  (sync_out)
	);

	isgp_link u_link (
		.i_scl      (i_scl),
		.i_link_rst (link_rst),
		.i_sda      (i_sda),
		.o_bit      (link_bit),
		.o_toggle   (link_tog)
	);

	assign scl_s   = sync_out[0];
	assign sda_s   = sync_out[1];
	assign gpio_s  = sync_out[4:2];
	assign ext_n_s = sync_out[5];
	assign tog_s   = sync_out[6];

	////////////////////////////////////////////////////////////////////////////////
	// Bus conditions

	logic        sys_rst;
	logic        scl_d;
	logic        sda_d;
	logic        tog_d;
	logic        start_evt;
	logic        stop_evt;
	logic        scl_fall;
	logic        bit_evt;

	assign sys_rst   = i_srst | ~ext_n_s;
	assign start_evt = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_evt  = scl_s & scl_d & ~sda_d & sda_s;
	assign scl_fall  = scl_d & ~scl_s;
	// Bit register holds steady a full SCL period, so reading it on the toggle is safe
	assign bit_evt   = tog_s ^ tog_d;

	always_ff @(posedge i_clk)
	begin
		scl_d    <= scl_s;
		sda_d    <= sda_s;
		link_rst <= sys_rst;
		if (sys_rst)
			tog_d <= 1'b0;
		else
			tog_d <= tog_s;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Framing

	isgp_state_t state;
	isgp_state_t next_state;
	logic [2:0]  cnt;
	logic [7:0]  shift;
	logic [7:0]  ptr;
	logic [7:0]  tx;
	logic        rw;
	logic [7:0]  byte_w;
	logic        last_bit;
	logic        addr_hit;
	logic        in_byte;
	logic        in_ack;
	logic        load_tx;
	logic        wr_en;
	logic        wr_ctrl;
	logic        wr_data;
	logic        target_oe;
	logic [5:0]  hold_cnt;

	function automatic logic [7:0] isgp_rd_byte(
		input logic [7:0] addr,
		input logic [2:0] dir,
		input logic       pwm,
		input logic [2:0] pins
	);
		logic [7:0] v;
		v = 8'h00;
		if (addr == `ISGP_REG_CTRL)
			v = {3'h0, pwm, 1'b0, dir};
		else if (addr == `ISGP_REG_DATA)
			v = {5'h00, pins};
		return v;
	endfunction : isgp_rd_byte

	logic [2:0]  dir;
	logic        pwm_en;
	logic [2:0]  dout;

	assign byte_w   = {shift[6:0], link_bit};
	assign last_bit = (cnt == 3'h7);
	assign addr_hit = (byte_w[7:1] == `ISGP_SLAVE_ADDR);
	assign in_byte  = (state == ST_ADDR) | (state == ST_PTR) | (state == ST_WDATA)
	                | (state == ST_RDATA);
	assign in_ack   = (state == ST_ACK_ADDR) | (state == ST_ACK_PTR)
	                | (state == ST_ACK_WDATA);
	assign load_tx  = bit_evt & ~start_evt & ~stop_evt & (next_state == ST_RDATA)
	                & (state != ST_RDATA);
	assign wr_en    = bit_evt & ~start_evt & ~stop_evt & (state == ST_ACK_WDATA);
	assign wr_ctrl  = wr_en & (ptr == `ISGP_REG_CTRL);
	assign wr_data  = wr_en & (ptr == `ISGP_REG_DATA);
	// Receiver pulls low in ack slots; as transmitter, release means a one
	assign target_oe = in_ack | ((state == ST_RDATA) & ~tx[7]);

	always_comb
	begin
		next_state = state;
		if (start_evt)
			next_state = ST_ADDR;
		else if (stop_evt)
			next_state = ST_IDLE;
		else if (bit_evt)
		begin
			unique case (state)
				ST_IDLE,
				ST_IGNORE:    next_state = state;
				ST_ADDR:      if (last_bit) next_state = addr_hit ? ST_ACK_ADDR : ST_IGNORE;
				ST_ACK_ADDR:  next_state = rw ? ST_RDATA : ST_PTR;
				ST_PTR:       if (last_bit) next_state = ST_ACK_PTR;
				ST_ACK_PTR,
				ST_ACK_WDATA: next_state = ST_WDATA;
				ST_WDATA:     if (last_bit) next_state = ST_ACK_WDATA;
				ST_RDATA:     if (last_bit) next_state = ST_RACK;
				ST_RACK:      next_state = link_bit ? ST_IGNORE : ST_RDATA;
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (sys_rst)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge i_clk)
	begin
		if (sys_rst || start_evt || (bit_evt && !in_byte))
			cnt <= 3'h0;
		else if (bit_evt)
			cnt <= cnt + 3'h1;
	end

	always_ff @(posedge i_clk)
	begin
		if (sys_rst)
		begin
			shift <= 8'h00;
			ptr   <= 8'h00;
			rw    <= 1'b0;
		end
		else if (bit_evt && !start_evt && !stop_evt)
		begin
			if (in_byte && state != ST_RDATA)
				shift <= byte_w;
			if (state == ST_ADDR && last_bit)
				rw <= link_bit;
			if (state == ST_ACK_PTR)
				ptr <= shift;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (sys_rst)
			tx <= 8'hff;
		else if (load_tx)
			tx <= isgp_rd_byte(ptr, dir, pwm_en, gpio_s);
		else if (bit_evt && state == ST_RDATA)
			tx <= {tx[6:0], 1'b1};
	end

	////////////////////////////////////////////////////////////////////////////////
	// SDA drive, moved only after an SCL fall plus the data hold time, or released at once on start or stop

	always_ff @(posedge i_clk)
	begin
		o_sda_out <= 1'b0;
		if (sys_rst || start_evt || stop_evt)
		begin
			hold_cnt <= 6'h00;
			o_sda_oe <= 1'b0;
		end
		else if (scl_fall)
			hold_cnt <= 6'(`ISGP_HOLD_CYC);
		else if (hold_cnt != 6'h00)
		begin
			hold_cnt <= hold_cnt - 6'h01;
			if (hold_cnt == 6'h01)
				o_sda_oe <= target_oe;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (sys_rst || stop_evt)
			o_bus_busy <= 1'b0;
		else if (start_evt)
			o_bus_busy <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin registers

	always_ff @(posedge i_clk)
	begin
		if (sys_rst)
		begin
			dir    <= `ISGP_DIR_RESET;
			pwm_en <= `ISGP_PWM_RESET;
			dout   <= `ISGP_DATA_RESET;
		end
		else
		begin
			if (wr_ctrl)
			begin
				dir    <= shift[2:0];
				pwm_en <= shift[`ISGP_CTRL_PWM_BIT];
			end
			if (wr_data)
				dout <= shift[2:0];
		end
	end

	// Registered pin drive; one cycle behind the registers
	always_ff @(posedge i_clk)
	begin
		if (sys_rst)
		begin
			o_gpio_oe   <= 3'h0;
			o_gpio_out  <= 3'h0;
			o_pwm_input <= 1'b0;
		end
		else
		begin
			o_gpio_oe   <= {dir[2:1], dir[0] & ~pwm_en};
			o_gpio_out  <= dout;
			o_pwm_input <= pwm_en & gpio_s[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (sys_rst);

	AST_DIR_TO_OE: assert property (
		##1 (o_gpio_oe[2:1] == $past(dir[2:1]))
	) else $error("pin enable does not follow direction bits");

	AST_PWM_OVERRIDE: assert property (
		pwm_en ##1 pwm_en |-> !o_gpio_oe[0]
	) else $error("pin zero driven while PWM input enabled");

	AST_OUT_DATA: assert property (
		wr_data ##1 dir[1] |=> (o_gpio_out[1] == $past(dout[1]))
	) else $error("output pin does not follow data register");

	AST_START_ADDR: assert property (
		start_evt |=> (state == ST_ADDR) && (cnt == 3'h0) && o_bus_busy
	) else $error("start did not restart address reception");

	AST_STOP_FREE: assert property (
		stop_evt |=> !o_bus_busy && (state == ST_IDLE)
	) else $error("bus still busy after stop");

	AST_ACK_DRIVE: assert property (
		(state == ST_ACK_PTR) && scl_fall |-> !o_sda_oe ##[25:35] o_sda_oe
	) else $error("no acknowledge after the hold time");

	AST_WRITE_LANDS: assert property (
		wr_ctrl |=> (dir == $past(shift[2:0])) ##2 (o_gpio_oe[2:1] == dir[2:1])
	) else $error("register write not applied at last acknowledge");

	AST_ADDR_MISS: assert property (
		bit_evt && !start_evt && !stop_evt && (state == ST_ADDR) && last_bit
		&& !addr_hit |=> (state == ST_IGNORE) [*2]
	) else $error("foreign address was not ignored");

	AST_SDA_STEADY: assert property (
		scl_s && scl_d && !start_evt && !stop_evt |-> $stable(o_sda_oe)
	) else $error("SDA drive changed while SCL high");

	AST_NACK_ENDS: assert property (
		bit_evt && !start_evt && !stop_evt && (state == ST_RACK) && link_bit
		|=> (state == ST_IGNORE)
	) else $error("read continued after master NACK");

endmodule : isgp_top

`default_nettype wire

// ===== bench/isgp_master.sv
// Two-wire bus master model facing the serial GPIO port.
// Assumes a pull-up on SDA, resolved outside from o_sda_low and the device's pull.
`timescale 1ns/1ns
`default_nettype none
`include "isgp_map.svh"

module isgp_master (
	input  wire logic i_sda,
	output var  logic o_scl,
	output var  logic o_sda_low
);
	// Slow fifth-of-a-bit step: device drive lags SCL fall by ~330 ns
	localparam int U = 210;

	initial
	begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// SDA moves only with SCL low, sampled mid high
	task automatic bit_x(input logic b, output logic r);
		#U o_sda_low = !b;
		#(2*U) o_scl = 1'b1;
		#U r = i_sda;
		#U o_scl = 1'b0;
	endtask : bit_x

	task automatic start();
		if (!o_scl)
		begin
			#U o_sda_low = 1'b0;
			#U o_scl = 1'b1;
		end
		#U o_sda_low = 1'b1;
		#U o_scl = 1'b0;
	endtask : start

	// SCL stands high after stop
	task automatic stop();
		#U o_sda_low = 1'b1;
		#(2*U) o_scl = 1'b1;
		#U o_sda_low = 1'b0;
		#(2*U);
	endtask : stop

	task automatic wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = !r;
	endtask : wr

	task automatic rd(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(!ack, r);
	endtask : rd

	////////////////////////////////////////////////////////////////////////////
	task automatic wreg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v,
		output logic ok);
		logic k0, k1, k2;
		start();
		wr({a, 1'b0}, k0);
		wr(p, k1);
		wr(v, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask : wreg

	task automatic rreg(input logic [7:0] p, output logic [7:0] v);
		logic k;
		start();
		wr({`ISGP_SLAVE_ADDR, 1'b0}, k);
		wr(p, k);
		start();
		wr({`ISGP_SLAVE_ADDR, 1'b1}, k);
		rd(1'b0, v);
		stop();
	endtask : rreg
endmodule : isgp_master
`default_nettype wire

// ===== bench/tb_i2c_slave_gpio_port.sv
// Self-checking bench of the serial GPIO port.
// Assumes the master model drives the bus; pins resolve from device and bench drive.
`timescale 1ns/1ns
`default_nettype none
`include "isgp_map.svh"

module tb_i2c_slave_gpio_port;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       ext_rst_n = 1'b1;
	logic [2:0] ext = 3'h0;
	wire        scl, sda_low, sda, sda_out, sda_oe, pwm_in, busy;
	wire  [2:0] gpio_out, gpio_oe, pins;
	int         n_errors = 0;
	int         comparisons = 0;

	assign sda = !(sda_low | sda_oe);
	assign pins = (gpio_oe & gpio_out) | (~gpio_oe & ext);

	always #5 clk = ~clk;

	isgp_master i_mst (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

	isgp_top i_dut (
		.i_clk(clk), .i_srst(srst), .i_external_reset_n(ext_rst_n), .i_scl(scl),
		.i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_gpio_in(pins),
		.o_gpio_out(gpio_out), .o_gpio_oe(gpio_oe), .o_pwm_input(pwm_in), .o_bus_busy(busy)
	);

	////////////////////////////////////////////////////////////////////////////
	// Value taken when called, compared after the next falling edge
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		@(negedge clk);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic put(input logic [7:0] p, input logic [7:0] v);
		logic ok;
		i_mst.wreg(`ISGP_SLAVE_ADDR, p, v, ok);
		chk("ack", 8'h01, {7'h0, ok});
	endtask : put

	task automatic get(input string n, input logic [7:0] p, input logic [7:0] e);
		logic [7:0] v;
		i_mst.rreg(p, v);
		chk(n, e, v);
	endtask : get

	task automatic end_sim();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim

	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("oe", 8'h00, {5'h0, gpio_oe});
		chk("outs", 8'h00, {5'h0, sda_out, pwm_in, busy});
		get("ctrl", `ISGP_REG_CTRL, 8'h00);
		@(posedge clk) ext <= 3'h5;
		get("pins in", `ISGP_REG_DATA, 8'h05);
		$display("test reset done");
	endtask : t_reset

	task automatic t_out();
		put(`ISGP_REG_CTRL, 8'h07);
		chk("oe", 8'h07, {5'h0, gpio_oe});
		@(posedge clk) ext <= 3'h3;
		put(`ISGP_REG_DATA, 8'h05);
		chk("out", 8'h05, {5'h0, gpio_out});
		get("pins out", `ISGP_REG_DATA, 8'h05);
		put(`ISGP_REG_CTRL, 8'h02);
		chk("oe", 8'h02, {5'h0, gpio_oe});
		get("pins mix", `ISGP_REG_DATA, 8'h01);
		$display("test output done");
	endtask : t_out

	task automatic t_pwm();
		put(`ISGP_REG_CTRL, 8'h13);
		chk("oe", 8'h02, {5'h0, gpio_oe});
		chk("pwm", 8'h01, {7'h0, pwm_in});
		get("ctrl", `ISGP_REG_CTRL, 8'h13);
		@(posedge clk) ext <= 3'h2;
		repeat (6) @(posedge clk);
		chk("pwm", 8'h00, {7'h0, pwm_in});
		$display("test pwm done");
	endtask : t_pwm

	task automatic t_addr();
		logic ok;
		i_mst.wreg(7'h5a, `ISGP_REG_CTRL, 8'h00, ok);
		chk("nack", 8'h00, {7'h0, ok});
		chk("oe", 8'h02, {5'h0, gpio_oe});
		get("unmapped", 8'h10, 8'h00);
		$display("test address done");
	endtask : t_addr

	// Write aborted by a repeated start, then redone
	task automatic t_rstart();
		logic k;
		i_mst.start();
		i_mst.wr({`ISGP_SLAVE_ADDR, 1'b0}, k);
		i_mst.wr(`ISGP_REG_CTRL, k);
		chk("busy", 8'h01, {7'h0, busy});
		i_mst.start();
		i_mst.wr({`ISGP_SLAVE_ADDR, 1'b0}, k);
		i_mst.wr(`ISGP_REG_CTRL, k);
		i_mst.wr(8'h04, k);
		i_mst.stop();
		chk("oe", 8'h04, {5'h0, gpio_oe});
		chk("busy", 8'h00, {7'h0, busy});
		$display("test repeated start done");
	endtask : t_rstart

	task automatic t_ext();
		put(`ISGP_REG_CTRL, 8'h17);
		@(posedge clk) ext_rst_n <= 1'b0;
		repeat (10) @(posedge clk);
		chk("oe", 8'h00, {5'h0, gpio_oe});
		chk("pwm", 8'h00, {7'h0, pwm_in});
		@(posedge clk) ext_rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		get("ctrl", `ISGP_REG_CTRL, 8'h00);
		$display("test external reset done");
	endtask : t_ext

	// Two data bytes to one register, then a read kept going by a master acknowledge
	task automatic t_burst();
		logic       k0, k1, k2, k3;
		logic [7:0] v0, v1;
		i_mst.start();
		i_mst.wr({`ISGP_SLAVE_ADDR, 1'b0}, k0);
		i_mst.wr(`ISGP_REG_CTRL, k1);
		i_mst.wr(8'h01, k2);
		i_mst.wr(8'h06, k3);
		i_mst.stop();
		chk("ack", 8'h01, {7'h0, k0 & k1 & k2 & k3});
		chk("oe", 8'h06, {5'h0, gpio_oe});
		i_mst.start();
		i_mst.wr({`ISGP_SLAVE_ADDR, 1'b0}, k0);
		i_mst.wr(`ISGP_REG_CTRL, k1);
		i_mst.start();
		i_mst.wr({`ISGP_SLAVE_ADDR, 1'b1}, k2);
		i_mst.rd(1'b1, v0);
		i_mst.rd(1'b0, v1);
		i_mst.stop();
		chk("ack", 8'h01, {7'h0, k0 & k1 & k2});
		chk("ctrl first", 8'h06, v0);
		chk("ctrl again", 8'h06, v1);
		$display("test burst done");
	endtask : t_burst

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		repeat (10) @(posedge clk);
		#3;
		t_reset();
		t_out();
		t_pwm();
		t_addr();
		t_rstart();
		t_ext();
		t_burst();
		end_sim();
	end

	// About 60k cycles expected; a stuck bus ends here
	initial
	begin
		repeat (100000) @(posedge clk);
		n_errors++;
		end_sim();
	end
endmodule : tb_i2c_slave_gpio_port
`default_nettype wire
